// ==== hw/edtp_core.sv ====
// Per-thread enclave debug, branch-record and performance policy logic
`timescale 1ns/1ps
`default_nettype none
`include "edtp_params.svh"

// Operation
// - Step or data-breakpoint trap inside enclave: async exit, report exit-pointer ibp matches
// - Async exit saves outside-equivalent resume flag; post-exit resume flag is zero
// - Implicit and management or entry leaf protected-memory accesses never hit data breakpoints
// - Opt-in key-derive and report leaf protected operands hit data breakpoints
// - All leaves hit data breakpoints on operands outside protected memory, except in-range operands inside an opt-out enclave
// - Trap opcodes f1 and cc fault inside enclave; invalid opcode after opt-out
// - Opt-in: f1 gives debug fault, cc breakpoint fault, no privilege check
// - Trap saves own address in save area; stack gets async exit pointer
// - Trap causing vm exit: hardware exception type 3, length zero
// - Branch stepping: step trap after opt-in entry leaf and after every exit leaf
// - Branch stepping: no step trap for resume leaf or async exit
// - Opt-in entry or resume pushes record from leaf address to destination
// - Opt-in exit leaf pushes record from exit address to its destination
// - Opt-in async exit pushes record from saved ip to exit pointer
// - Opt-in branches inside enclave push records
// - Opt-out entry suppresses recording, pushes nothing; leaving ends suppression
// - Opt-out with recording enabled: exit leaf pushes entering address to destination
// - Opt-out async exit pushes entry-to-pointer record; later event record sources pointer
// - Container records carry predicted bit 63 and are non-transactional
// - Container transitions are far branches, filtered by filter bit 8
// - Global perf status bit 60 is side-channel indicator
// - Opt-in entry keeps counting and leaves indicator clear
// - Opt-in flag zero means opt-out, one means opt-in
// - Opt-out: suppress ibp inside, data bp only outside container range
// - Opt-out entry stops counters, suppresses precise events, sets indicator
module edtp_core
  import edtp_pkg::*;
#(
  parameter int NUM_IBP = `EDTP_NUM_IBP
) (
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Container transitions from the core
  input wire edtp_op_e op_kind,
  input wire logic debug_opt_in_flag,
  input wire logic [63:0] op_instr_ip,
  input wire logic [63:0] op_dest_ip,
  input wire logic [63:0] async_exit_pointer,
  input wire logic [63:0] save_area_ip_in,
  input wire logic resume_flag_outside,
  input wire logic branch_record_en,
  input wire logic branch_step_flag,
  input wire logic [63:0] branch_record_filter,
  // Branches and events inside the container
  input wire logic branch_taken,
  input wire logic [63:0] branch_source,
  input wire logic [63:0] branch_target,
  input wire logic cause_event_push,
  input wire logic [63:0] cause_event_target,
  input wire logic step_or_data_trap,
  input wire logic trap_instr_exec,
  input wire logic [7:0] trap_opcode,
  input wire logic [63:0] trap_instr_ip,
  input wire logic trap_vm_exit,
  // Breakpoint qualification
  input wire logic [NUM_IBP*64-1:0] ibp_addr,
  input wire logic [NUM_IBP-1:0] ibp_enable,
  input wire logic mem_access,
  input wire logic mem_implicit,
  input wire logic mem_protected,
  input wire logic mem_in_range,
  input wire logic leaf_mgmt_or_entry,
  input wire logic leaf_key_or_report,
  input wire logic dbp_match_raw,
  input wire logic ibp_match_raw,
  // Results
  output logic inside_enclave,
  output logic opt_in_active,
  output logic dbp_fire,
  output logic ibp_fire,
  output logic async_exit_req,
  output logic [NUM_IBP-1:0] debug_status_ibp,
  output logic saved_resume_flag,
  output logic resume_flag_post,
  output edtp_trap_s trap_out,
  output logic [2:0] vm_exit_evt_type,
  output logic [3:0] vm_exit_instr_len,
  output logic step_trap,
  output edtp_branch_rec_s rec_out,
  output logic counters_stopped,
  output logic precise_suppressed,
  output logic side_channel_indicator
);

  // Elaboration-time refusal of unsupported breakpoint counts
  if (NUM_IBP < 1 || NUM_IBP > 8) begin : g_bad_num_ibp
    $error("NUM_IBP out of range");
  end

  edtp_mode_e mode;
  logic optout_rec_en;
  logic [63:0] entry_ip;
  logic pend_cause_push;
  logic [31:0] ctrl;
  logic [31:0] event_count;
  logic sci_clear_req;
  logic [NUM_IBP-1:0] aep_match;
  logic kept;

  assign inside_enclave = (mode == edtp_inside);
  assign kept = branch_record_filter[`EDTP_FILTER_FAR_BIT] == 1'b0 && !ctrl[0];

  // Entry type and mode state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= edtp_outside;
      opt_in_active <= 1'b0;
      optout_rec_en <= 1'b0;
      entry_ip <= 64'h0;
    end else begin
      case (op_kind)
        edtp_op_entry, edtp_op_resume: begin
          mode <= edtp_inside;
          opt_in_active <= debug_opt_in_flag;
          optout_rec_en <= !debug_opt_in_flag && branch_record_en;
          entry_ip <= op_instr_ip;
        end
        edtp_op_exit, edtp_op_async_exit: begin
          mode <= edtp_outside;
          opt_in_active <= 1'b0;
          optout_rec_en <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Breakpoint qualification
  always_comb begin
    dbp_fire = 1'b0;
    if (mem_access && dbp_match_raw) begin
      if (!mem_protected) dbp_fire = 1'b1;
      else if (mem_implicit || leaf_mgmt_or_entry) dbp_fire = 1'b0;
      else if (leaf_key_or_report) dbp_fire = inside_enclave && opt_in_active;
      else if (inside_enclave && !opt_in_active) dbp_fire = !mem_in_range;
      else dbp_fire = 1'b1;
    end
    if (mem_access && dbp_match_raw && !mem_protected && inside_enclave && !opt_in_active) begin
      dbp_fire = !mem_in_range;
    end
  end
  assign ibp_fire = ibp_match_raw && !(inside_enclave && !opt_in_active);
  assign async_exit_req = inside_enclave && step_or_data_trap;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IBP; gi++) begin : g_ibp
      assign aep_match[gi] = ibp_enable[gi] && ibp_addr[gi*64 +: 64] == async_exit_pointer;
    end
  endgenerate

  // Status reporting after async exit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      debug_status_ibp <= '0;
      saved_resume_flag <= 1'b0;
      resume_flag_post <= 1'b0;
    end else if (op_kind == edtp_op_async_exit) begin
      if (step_or_data_trap) debug_status_ibp <= debug_status_ibp | aep_match;
      saved_resume_flag <= resume_flag_outside;
      resume_flag_post <= 1'b0;
    end
  end

  // One-byte trap handling
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trap_out <= '0;
      vm_exit_evt_type <= 3'h0;
      vm_exit_instr_len <= 4'h0;
    end else begin
      trap_out.valid <= 1'b0;
      if (trap_instr_exec && inside_enclave &&
          (trap_opcode == `EDTP_OP_TRAP_DEBUG || trap_opcode == `EDTP_OP_TRAP_BREAK)) begin
        trap_out.valid <= 1'b1;
        trap_out.fault_class <= 1'b1;
        if (!opt_in_active) begin
          trap_out.vector <= `EDTP_VEC_INVALID;
          trap_out.skip_priv_check <= 1'b0;
        end else begin
          trap_out.vector <= (trap_opcode == `EDTP_OP_TRAP_DEBUG) ?
                             `EDTP_VEC_DEBUG : `EDTP_VEC_BREAK;
          trap_out.skip_priv_check <= 1'b1;
        end
        trap_out.save_area_ip <= trap_instr_ip;
        trap_out.stack_ip <= async_exit_pointer;
        if (trap_vm_exit) begin
          vm_exit_evt_type <= `EDTP_EVT_TYPE_HW_EXC;
          vm_exit_instr_len <= 4'h0;
        end
      end
    end
  end

  // Branch stepping trap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_trap <= 1'b0;
    end else begin
      step_trap <= branch_step_flag &&
                   ((op_kind == edtp_op_entry && debug_opt_in_flag) ||
                    (op_kind == edtp_op_exit && inside_enclave));
    end
  end

  // Branch record generation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rec_out <= '0;
      pend_cause_push <= 1'b0;
    end else begin
      rec_out.valid <= 1'b0;
      rec_out.far_branch <= 1'b1;
      rec_out.transactional <= 1'b0;
      if (pend_cause_push) begin
        // The causing event owns this record, so it is not a container record
        pend_cause_push <= 1'b0;
        rec_out.valid <= 1'b1;
        rec_out.far_branch <= 1'b0;
        rec_out.source <= async_exit_pointer;
        rec_out.target <= cause_event_target;
      end else if (branch_record_en && kept &&
                   (op_kind == edtp_op_entry || op_kind == edtp_op_resume) &&
                   debug_opt_in_flag) begin
        rec_out.valid <= 1'b1;
        rec_out.source <= {1'b1, op_instr_ip[62:0]};
        rec_out.target <= op_dest_ip;
      end else if (inside_enclave && op_kind == edtp_op_exit) begin
        rec_out.valid <= kept && (opt_in_active ? branch_record_en : optout_rec_en);
        rec_out.source <= {1'b1, opt_in_active ? op_instr_ip[62:0]
                                                : entry_ip[62:0]};
        rec_out.target <= op_dest_ip;
      end else if (inside_enclave && op_kind == edtp_op_async_exit) begin
        rec_out.valid <= kept && (opt_in_active ? branch_record_en : optout_rec_en);
        rec_out.source <= {1'b1, opt_in_active ? save_area_ip_in[62:0]
                                                : entry_ip[62:0]};
        rec_out.target <= async_exit_pointer;
        pend_cause_push <= !opt_in_active && optout_rec_en && cause_event_push;
      end else if (inside_enclave && opt_in_active && branch_taken && branch_record_en) begin
        rec_out.valid <= 1'b1;
        rec_out.far_branch <= 1'b0;
        rec_out.source <= branch_source;
        rec_out.target <= branch_target;
      end
    end
  end

  // Performance monitoring suppression
  assign counters_stopped = inside_enclave && !opt_in_active;
  assign precise_suppressed = inside_enclave && !opt_in_active;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      side_channel_indicator <= 1'b0;
    end else if ((op_kind == edtp_op_entry || op_kind == edtp_op_resume) && !debug_opt_in_flag) begin
      side_channel_indicator <= 1'b1;
    end else if (sci_clear_req) begin
      side_channel_indicator <= 1'b0;
    end
  end

  // Register bus
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `EDTP_CTRL_RESET;
      event_count <= 32'h0;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
      sci_clear_req <= 1'b0;
    end else begin
      sci_clear_req <= 1'b0;
      if (rec_out.valid) event_count <= event_count + 32'h1;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      // Writes land at the edge where the master sees waitrequest low
      if (avs_write && !avs_waitrequest) begin
        if (avs_address == `EDTP_REG_CTRL && avs_byteenable[0]) begin
          ctrl[7:0] <= avs_writedata[7:0];
        end
        if (avs_address == `EDTP_REG_PERF_HI && avs_byteenable[3]) begin
          sci_clear_req <= avs_writedata[`EDTP_SCI_BIT-32];
        end
      end
      if ((avs_read || avs_write) && avs_waitrequest) begin
        if (avs_read) begin
          case (avs_address)
            `EDTP_REG_CTRL: avs_readdata <= ctrl;
            `EDTP_REG_STATUS: avs_readdata <= {28'h0, step_trap, optout_rec_en,
                                               opt_in_active, inside_enclave};
            `EDTP_REG_PERF_HI: avs_readdata <= {3'h0, side_channel_indicator, 28'h0};
            `EDTP_REG_EVENTS: avs_readdata <= event_count;
            default: avs_readdata <= 32'h0;
          endcase
        end
      end
    end
  end

endmodule : edtp_core
`default_nettype wire

// ==== inc/edtp_params.svh ====
// Constants for the enclave debug and trace policy block
`ifndef EDTP_PARAMS_SVH
`define EDTP_PARAMS_SVH
`define EDTP_ADDR_W 64
`define EDTP_NUM_IBP 4
`define EDTP_OP_TRAP_DEBUG 8'hf1
`define EDTP_OP_TRAP_BREAK 8'hcc
`define EDTP_VEC_DEBUG 8'h01
`define EDTP_VEC_BREAK 8'h03
`define EDTP_VEC_INVALID 8'h06
`define EDTP_EVT_TYPE_HW_EXC 3'h3
`define EDTP_PRED_BIT 63
`define EDTP_FILTER_FAR_BIT 8
`define EDTP_SCI_BIT 60
// Avalon register offsets (byte addresses)
`define EDTP_REG_CTRL 4'h0
`define EDTP_REG_STATUS 4'h4
`define EDTP_REG_PERF_HI 4'h8
`define EDTP_REG_EVENTS 4'hc
`define EDTP_CTRL_RESET 32'h0000_0000
`endif

// ==== inc/edtp_pkg.sv ====
// Types for the enclave debug and trace policy block
package edtp_pkg;
  typedef enum logic [2:0] {
    edtp_op_none,
    edtp_op_entry,
    edtp_op_resume,
    edtp_op_exit,
    edtp_op_async_exit
  } edtp_op_e;

  typedef enum logic {
    edtp_outside,
    edtp_inside
  } edtp_mode_e;

  typedef struct packed {
    logic valid;
    logic [63:0] source;
    logic [63:0] target;
    logic far_branch;
    logic transactional;
  } edtp_branch_rec_s;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic fault_class;
    logic skip_priv_check;
    logic [63:0] save_area_ip;
    logic [63:0] stack_ip;
  } edtp_trap_s;
endpackage : edtp_pkg

// ==== verification/edtp_core_assertions.sv ====
// Concurrent property checks bound to the policy block ports
`timescale 1ns/1ps
`default_nettype none
module edtp_core_assertions
  import edtp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire edtp_op_e op_kind,
  input wire logic debug_opt_in_flag,
  input wire logic [63:0] async_exit_pointer,
  input wire logic branch_step_flag,
  input wire logic trap_instr_exec,
  input wire logic [7:0] trap_opcode,
  input wire logic [63:0] trap_instr_ip,
  input wire logic trap_vm_exit,
  input wire logic mem_in_range,
  input wire logic inside_enclave,
  input wire logic opt_in_active,
  input wire logic dbp_fire,
  input wire edtp_trap_s trap_out,
  input wire logic [2:0] vm_exit_evt_type,
  input wire logic [3:0] vm_exit_instr_len,
  input wire logic step_trap,
  input wire edtp_branch_rec_s rec_out,
  input wire logic counters_stopped,
  input wire logic precise_suppressed,
  input wire logic side_channel_indicator
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire trap_in = trap_instr_exec && inside_enclave && trap_opcode inside {8'hf1, 8'hcc};
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("accept lasted more than one cycle");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
    else $error("bus request not answered");
  entry_type_a: assert property (op_kind == edtp_op_entry |=> inside_enclave && opt_in_active == $past(debug_opt_in_flag))
    else $error("entry type not taken from flag");
  type_hold_a: assert property (inside_enclave && op_kind == edtp_op_none |=> inside_enclave && $stable(opt_in_active))
    else $error("entry type changed inside");
  trap_optout_a: assert property (trap_in && !opt_in_active |=> trap_out.valid && trap_out.fault_class && trap_out.vector == 8'h06)
    else $error("opt-out trap not invalid opcode");
  break_optin_a: assert property (trap_in && opt_in_active && trap_opcode == 8'hcc |=> trap_out.vector == 8'h03 && trap_out.skip_priv_check)
    else $error("opt-in break trap wrong");
  trap_ip_a: assert property (trap_in |=> trap_out.save_area_ip == $past(trap_instr_ip) && trap_out.stack_ip == $past(async_exit_pointer))
    else $error("trap pointers wrong");
  vm_exit_a: assert property (trap_in && trap_vm_exit |=> vm_exit_evt_type == 3'h3 && vm_exit_instr_len == 4'h0)
    else $error("vm exit event info wrong");
  step_entry_a: assert property (op_kind == edtp_op_entry && debug_opt_in_flag && branch_step_flag |=> step_trap)
    else $error("missing step trap after entry");
  no_step_a: assert property (op_kind inside {edtp_op_resume, edtp_op_async_exit} |=> !step_trap)
    else $error("unexpected step trap");
  rec_pred_a: assert property (rec_out.valid && rec_out.far_branch |-> rec_out.source[63] && !rec_out.transactional)
    else $error("container record not predicted");
  range_quiet_a: assert property (inside_enclave && !opt_in_active && mem_in_range |-> !dbp_fire)
    else $error("data breakpoint inside range");
  optout_perf_a: assert property (op_kind inside {edtp_op_entry, edtp_op_resume} && !debug_opt_in_flag |=> counters_stopped && precise_suppressed && side_channel_indicator)
    else $error("counters not stopped");
  cover property (op_kind == edtp_op_entry && !debug_opt_in_flag);
  cover property (rec_out.valid && rec_out.far_branch);
  cover property (trap_out.valid && trap_out.vector == 8'h06);
endmodule : edtp_core_assertions
bind edtp_core edtp_core_assertions i_edtp_core_assertions (.*);
`default_nettype wire

// ==== verification/edtp_core_bench.sv ====
// Self-checking bench for the enclave debug and trace policy block
`timescale 1ns/1ps
`default_nettype none
module edtp_core_bench;
  import edtp_pkg::*;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, debug_opt_in_flag, resume_flag_outside;
  logic branch_record_en, branch_step_flag, branch_taken, cause_event_push, step_or_data_trap;
  logic trap_instr_exec, trap_vm_exit, mem_access, mem_implicit, mem_protected, mem_in_range;
  logic leaf_mgmt_or_entry, leaf_key_or_report, dbp_match_raw, ibp_match_raw, inside_enclave;
  logic opt_in_active, dbp_fire, ibp_fire, async_exit_req, saved_resume_flag, resume_flag_post;
  logic step_trap, counters_stopped, precise_suppressed, side_channel_indicator;
  logic [3:0] avs_address, avs_byteenable, ibp_enable, debug_status_ibp, vm_exit_instr_len;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [63:0] op_instr_ip, op_dest_ip, async_exit_pointer, save_area_ip_in, branch_record_filter;
  logic [63:0] branch_source, branch_target, cause_event_target, trap_instr_ip, ent_ip;
  logic [255:0] ibp_addr;
  logic [7:0] trap_opcode;
  logic [2:0] vm_exit_evt_type;
  edtp_op_e op_kind;
  edtp_trap_s trap_out;
  edtp_branch_rec_s rec_out, e;
  edtp_branch_rec_s exp_q[$];
  int bad_count = 0;
  int checked = 0;
  int recs = 0;
  logic in_m = 0;
  logic oi = 0;
  logic oo_rec = 0;
  logic sw_off = 0;
  edtp_core i_edtp_core (.*);
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [139:0] s, input logic [139:0] x);
    checked++;
    if (s !== x) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic push(input logic [63:0] s, input logic [63:0] t, input logic f);
    if (!(f && (branch_record_filter[8] || sw_off))) begin
      exp_q.push_back('{1'b1, {f | s[63], s[62:0]}, t, f, 1'b0});
      recs++;
    end
  endtask : push
  always @(posedge mclk) begin
    if (rec_out.valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : '0;
      if (e.far_branch) chk(rec_out, e);
      else chk({rec_out.source[62:0], rec_out.target}, {e.source[62:0], e.target});
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (n >= 20) chk(1, 0);
  endtask : bus
  task automatic op(input edtp_op_e k, input logic f);
    logic [63:0] ip, d, a;
    ip = {$urandom, $urandom};
    d = {$urandom, $urandom};
    a = {$urandom, $urandom};
    @(posedge mclk);
    op_kind <= k;
    debug_opt_in_flag <= f;
    op_instr_ip <= ip;
    op_dest_ip <= d;
    async_exit_pointer <= a;
    ibp_addr[63:0] <= a;
    save_area_ip_in <= {$urandom, $urandom};
    resume_flag_outside <= $urandom;
    @(posedge mclk);
    op_kind <= edtp_op_none;
    #1;
    if (k == edtp_op_entry || k == edtp_op_resume) begin
      if (f && branch_record_en) push(ip, d, 1);
      chk(step_trap, k == edtp_op_entry && f && branch_step_flag);
      in_m = 1;
      oi = f;
      oo_rec = !f && branch_record_en;
      ent_ip = ip;
    end else if (k == edtp_op_exit) begin
      if (oi && branch_record_en) push(ip, d, 1);
      if (!oi && oo_rec) push(ent_ip, d, 1);
      chk(step_trap, in_m && branch_step_flag);
      in_m = 0;
    end else begin
      if (oi && branch_record_en) push(save_area_ip_in, a, 1);
      if (!oi && oo_rec) push(ent_ip, a, 1);
      if (!oi && oo_rec && cause_event_push) push(a, cause_event_target, 0);
      chk(step_trap, 0);
      chk({saved_resume_flag, resume_flag_post}, {resume_flag_outside, 1'b0});
      in_m = 0;
    end
    chk(inside_enclave, in_m);
    if (in_m) chk(opt_in_active, oi);
  endtask : op
  task automatic trap(input logic [7:0] opc, input logic vm);
    logic [63:0] tip;
    tip = {$urandom, $urandom};
    @(posedge mclk);
    trap_instr_exec <= 1;
    trap_opcode <= opc;
    trap_instr_ip <= tip;
    trap_vm_exit <= vm;
    @(posedge mclk);
    trap_instr_exec <= 0;
    #1;
    chk({trap_out.valid, trap_out.fault_class, trap_out.vector},
        {2'b11, oi ? (opc == 8'hf1 ? 8'h01 : 8'h03) : 8'h06});
    if (oi) chk(trap_out.skip_priv_check, 1);
    chk({trap_out.save_area_ip, trap_out.stack_ip}, {tip, async_exit_pointer});
    if (vm) chk({vm_exit_evt_type, vm_exit_instr_len}, 7'h30);
  endtask : trap
  task automatic dbs(input logic [5:0] v, input logic x);
    @(posedge mclk);
    {mem_access, mem_implicit, mem_protected, mem_in_range, leaf_mgmt_or_entry} <= v[5:1];
    leaf_key_or_report <= v[0];
    #1;
    chk(dbp_fire, x);
  endtask : dbs
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {rst_n, avs_read, avs_write, debug_opt_in_flag, resume_flag_outside, branch_taken} = '0;
    {cause_event_push, step_or_data_trap, trap_instr_exec, trap_vm_exit, mem_access} = '0;
    {mem_implicit, mem_protected, mem_in_range, leaf_mgmt_or_entry, leaf_key_or_report} = '0;
    {avs_address, avs_writedata, op_instr_ip, op_dest_ip, async_exit_pointer} = '0;
    {save_area_ip_in, branch_record_filter, branch_source, branch_target} = '0;
    {cause_event_target, trap_instr_ip, ibp_addr, trap_opcode} = '0;
    {branch_record_en, branch_step_flag, dbp_match_raw, ibp_match_raw} = '1;
    avs_byteenable = 4'hf;
    ibp_enable = 4'h1;
    op_kind = edtp_op_none;
    void'($urandom(32'h3ccd));
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    #1;
    chk({avs_waitrequest, inside_enclave, side_channel_indicator}, 3'b100);
    dbs(6'b111000, 0);
    dbs(6'b101010, 0);
    dbs(6'b100010, 1);
    op(edtp_op_entry, 1);
    chk({side_channel_indicator, counters_stopped, ibp_fire}, 3'b001);
    dbs(6'b101101, 1);
    bus(0, 4'h4, 0);
    chk(q[1:0], 2'b11);
    @(posedge mclk);
    branch_taken <= 1;
    branch_source <= {$urandom, $urandom};
    branch_target <= {$urandom, $urandom};
    @(posedge mclk);
    branch_taken <= 0;
    push(branch_source, branch_target, 0);
    trap(8'hf1, 0);
    trap(8'hcc, 1);
    @(posedge mclk);
    step_or_data_trap <= 1;
    #1;
    chk(async_exit_req, 1);
    op(edtp_op_async_exit, 1);
    chk(debug_status_ibp, 4'h1);
    @(posedge mclk);
    step_or_data_trap <= 0;
    op(edtp_op_resume, 1);
    op(edtp_op_exit, 1);
    op(edtp_op_entry, 0);
    chk({side_channel_indicator, counters_stopped, precise_suppressed, ibp_fire}, 4'he);
    dbs(6'b100100, 0);
    dbs(6'b100000, 1);
    trap(8'hf1, 0);
    @(posedge mclk);
    cause_event_push <= 1;
    cause_event_target <= {$urandom, $urandom};
    op(edtp_op_async_exit, 0);
    @(posedge mclk);
    cause_event_push <= 0;
    op(edtp_op_entry, 0);
    op(edtp_op_exit, 0);
    bus(0, 4'h8, 0);
    chk(q[28], 1);
    bus(1, 4'h8, 32'h1000_0000);
    bus(0, 4'h8, 0);
    chk(q[28], 0);
    bus(0, 4'h2, 0);
    chk(q, 0);
    bus(0, 4'hc, 0);
    chk(q, recs);
    @(posedge mclk);
    branch_record_filter <= 64'h100;
    branch_step_flag <= 0;
    op(edtp_op_entry, 1);
    chk(side_channel_indicator, 0);
    op(edtp_op_exit, 1);
    bus(1, 4'h0, 32'h1);
    bus(0, 4'h0, 0);
    chk(q, 32'h1);
    sw_off = 1;
    branch_record_filter <= 64'h0;
    op(edtp_op_entry, 1);
    op(edtp_op_exit, 1);
    repeat (4) @(posedge mclk);
    chk(exp_q.size(), 0);
    report_and_stop();
  end
endmodule : edtp_core_bench
`default_nettype wire
